// [core/lfm_pkg.sv]
// Functional notes
// - Each pin decodes input codes 1,2,3,4,9,10,11,20.
// - Code 21, positive limit input, is accepted on pin one only.
// - Code 22, negative limit input, is accepted on pin two only.
// - Every pin accepts output codes 101, 102, 103.
// - Fault reset and enable inputs act only in local control mode.
// - Selection writes accepted only while the power stage is disabled.
// - Stored value takes effect only at the next power-on.
// - Free input pin levels are readable through the readback register.
// - Factory defaults: limit positive, limit negative, free input, reference switch.
`default_nettype none
package lfm_pkg;
    localparam int NUM_PINS = 4;
    localparam int SEL_W = 16;
    localparam int ADDR_W = 12;
    // register offsets
    localparam logic [11:0] OFS_PIN1_SEL = 12'h722;
    localparam logic [11:0] OFS_PIN2_SEL = 12'h724;
    localparam logic [11:0] OFS_PIN3_SEL = 12'h726;
    localparam logic [11:0] OFS_PIN4_SEL = 12'h728;
    localparam logic [11:0] OFS_READBACK = 12'h72A;
    localparam logic [11:0] OFS_ACTIVE_BASE = 12'h730;
    // function codes
    localparam logic [15:0] FN_FREE_IN = 16'h0001;
    localparam logic [15:0] FN_FAULT_RESET = 16'h0002;
    localparam logic [15:0] FN_ENABLE = 16'h0003;
    localparam logic [15:0] FN_HALT = 16'h0004;
    localparam logic [15:0] FN_JOG_POS = 16'h0009;
    localparam logic [15:0] FN_JOG_NEG = 16'h000A;
    localparam logic [15:0] FN_JOG_FAST = 16'h000B;
    localparam logic [15:0] FN_REF_SW = 16'h0014;
    localparam logic [15:0] FN_LIM_POS = 16'h0015;
    localparam logic [15:0] FN_LIM_NEG = 16'h0016;
    localparam logic [15:0] FN_FREE_OUT = 16'h0065;
    localparam logic [15:0] FN_NO_FAULT = 16'h0066;
    localparam logic [15:0] FN_ACTIVE = 16'h0067;
    // factory defaults per pin
    localparam logic [15:0] RST_PIN1 = 16'h0015;
    localparam logic [15:0] RST_PIN2 = 16'h0016;
    localparam logic [15:0] RST_PIN3 = 16'h0001;
    localparam logic [15:0] RST_PIN4 = 16'h0014;
    // decoded input functions going to the drive logic
    typedef struct packed {
        logic fault_reset;
        logic enable;
        logic halt;
        logic jog_pos;
        logic jog_neg;
        logic jog_fast;
        logic ref_switch;
        logic positive_limit_input;
        logic negative_limit_input;
    } lfm_func_in_t;
    // output function sources from the drive logic
    typedef struct packed {
        logic no_fault;
        logic active;
    } lfm_func_out_t;
    // register read or write request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [15:0] wdata;
    } lfm_req_t;
endpackage
`default_nettype wire

// [core/lfm_pin_decode.sv]
`timescale 1ns/1ps
`default_nettype none
// decodes one pin's active code into its role
module lfm_pin_decode #(
    parameter int PIN_INDEX = 0
) (
    input wire logic [15:0] code_in,
    output logic valid_out,
    output logic is_output_out,
    output logic is_free_in_out
);
    wire logic in_common;
    wire logic out_common;
    // common input and output codes
    assign in_common = (code_in == lfm_pkg::FN_FREE_IN) || (code_in == lfm_pkg::FN_FAULT_RESET)
        || (code_in == lfm_pkg::FN_ENABLE) || (code_in == lfm_pkg::FN_HALT)
        || (code_in == lfm_pkg::FN_JOG_POS) || (code_in == lfm_pkg::FN_JOG_NEG)
        || (code_in == lfm_pkg::FN_JOG_FAST) || (code_in == lfm_pkg::FN_REF_SW);
    assign out_common = (code_in == lfm_pkg::FN_FREE_OUT) || (code_in == lfm_pkg::FN_NO_FAULT)
        || (code_in == lfm_pkg::FN_ACTIVE);
    assign valid_out = in_common || out_common
        || ((PIN_INDEX == 0) && (code_in == lfm_pkg::FN_LIM_POS))
        || ((PIN_INDEX == 1) && (code_in == lfm_pkg::FN_LIM_NEG));
    assign is_output_out = out_common;
    assign is_free_in_out = (code_in == lfm_pkg::FN_FREE_IN);
endmodule
`default_nettype wire

// [core/lfm_local_io_mux.sv]
`timescale 1ns/1ps
`default_nettype none
// four-pin local i/o function selector
module lfm_local_io_mux (
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire lfm_pkg::lfm_req_t req_in,
    output logic [15:0] rdata_out,
    output logic ack_out,
    output logic err_out,
    input wire logic power_stage_enabled_in,
    input wire logic local_control_mode_in,
    input wire logic [3:0] pin_level_in,
    output logic [3:0] pin_out,
    output logic [3:0] pin_oe_out,
    input wire logic [3:0] free_out_level_in,
    input wire lfm_pkg::lfm_func_out_t func_out_in,
    output lfm_pkg::lfm_func_in_t func_in_out
);
    localparam int N = lfm_pkg::NUM_PINS;
    // persistent stored values and power-on active copies
    logic [15:0] stored_reg [N] = '{lfm_pkg::RST_PIN1, lfm_pkg::RST_PIN2, lfm_pkg::RST_PIN3,
        lfm_pkg::RST_PIN4};
    logic boot_reg;
    logic [15:0] active_reg [N];
    logic [N-1:0] wr_valid;
    logic [N-1:0] act_valid;
    logic [N-1:0] act_is_out;
    logic [N-1:0] act_free_in;
    logic [N-1:0] hit;
    logic [3:0] readback_reg;
    logic [15:0] rdata_next;
    logic ack_reg;
    logic err_reg;
    wire logic write_allowed;

    function automatic logic [11:0] pin_offset(input int i);
        case (i)
            0: pin_offset = lfm_pkg::OFS_PIN1_SEL;
            1: pin_offset = lfm_pkg::OFS_PIN2_SEL;
            2: pin_offset = lfm_pkg::OFS_PIN3_SEL;
            default: pin_offset = lfm_pkg::OFS_PIN4_SEL;
        endcase
    endfunction

    function automatic logic [15:0] pin_default(input int i);
        case (i)
            0: pin_default = lfm_pkg::RST_PIN1;
            1: pin_default = lfm_pkg::RST_PIN2;
            2: pin_default = lfm_pkg::RST_PIN3;
            default: pin_default = lfm_pkg::RST_PIN4;
        endcase
    endfunction

    // writes only while the power stage is off
    assign write_allowed = !power_stage_enabled_in;

    // high from power-on until the first edge after it, when the active copies load
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            boot_reg <= 1'b1;
        end else begin
            boot_reg <= 1'b0;
        end
    end

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_pin
            logic [15:0] wdata_code;
            assign wdata_code = req_in.wdata;
            lfm_pin_decode #(.PIN_INDEX(g)) u_wr_dec (
                .code_in(wdata_code),
                .valid_out(wr_valid[g]),
                .is_output_out(),
                .is_free_in_out()
            );
            lfm_pin_decode #(.PIN_INDEX(g)) u_act_dec (
                .code_in(active_reg[g]),
                .valid_out(act_valid[g]),
                .is_output_out(act_is_out[g]),
                .is_free_in_out(act_free_in[g])
            );
            assign hit[g] = (req_in.addr == pin_offset(g));
            // stored value updates on accepted writes only; no reset, so it survives power-on
            always_ff @(posedge clock_in) begin
                if (req_in.wr && hit[g] && write_allowed && wr_valid[g]) begin
                    stored_reg[g] <= req_in.wdata;
                end
            end
            // active copy takes the stored value once, on the first edge after power-on
            // while in reset every pin sits in its default input role, so nothing drives
            always_ff @(posedge clock_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    active_reg[g] <= pin_default(g);
                end else if (boot_reg) begin
                    active_reg[g] <= stored_reg[g];
                end
            end
            // outputs drive only on output functions
            assign pin_oe_out[g] = act_valid[g] && act_is_out[g];
            assign pin_out[g] = (active_reg[g] == lfm_pkg::FN_FREE_OUT) ? free_out_level_in[g] :
                (active_reg[g] == lfm_pkg::FN_NO_FAULT) ? func_out_in.no_fault :
                (active_reg[g] == lfm_pkg::FN_ACTIVE) ? func_out_in.active : 1'b0;
        end
    endgenerate

    // function of an input code, or-ed over pins that carry it
    function automatic logic any_pin(input logic [15:0] code);
        logic r;
        r = 1'b0;
        for (int i = 0; i < N; i++) begin
            if (active_reg[i] == code && !act_is_out[i]) begin
                r = r | pin_level_in[i];
            end
        end
        return r;
    endfunction

    // route input levels to functions
    always_comb begin
        func_in_out.fault_reset = any_pin(lfm_pkg::FN_FAULT_RESET) && local_control_mode_in;
        func_in_out.enable = any_pin(lfm_pkg::FN_ENABLE) && local_control_mode_in;
        func_in_out.halt = any_pin(lfm_pkg::FN_HALT);
        func_in_out.jog_pos = any_pin(lfm_pkg::FN_JOG_POS);
        func_in_out.jog_neg = any_pin(lfm_pkg::FN_JOG_NEG);
        func_in_out.jog_fast = any_pin(lfm_pkg::FN_JOG_FAST);
        func_in_out.ref_switch = any_pin(lfm_pkg::FN_REF_SW);
        func_in_out.positive_limit_input = any_pin(lfm_pkg::FN_LIM_POS);
        func_in_out.negative_limit_input = any_pin(lfm_pkg::FN_LIM_NEG);
    end

    // free input levels sampled for readback
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            readback_reg <= 4'h0;
        end else begin
            readback_reg <= pin_level_in & act_free_in;
        end
    end

    // read mux
    always_comb begin
        rdata_next = 16'h0000;
        for (int i = 0; i < N; i++) begin
            if (hit[i]) begin
                rdata_next = stored_reg[i];
            end
            if (req_in.addr == (lfm_pkg::OFS_ACTIVE_BASE + 12'(2 * i))) begin
                rdata_next = active_reg[i];
            end
        end
        if (req_in.addr == lfm_pkg::OFS_READBACK) begin
            rdata_next = {12'h000, readback_reg};
        end
    end

    // answer one cycle after each request
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rdata_out <= 16'h0000;
            ack_reg <= 1'b0;
            err_reg <= 1'b0;
        end else begin
            ack_reg <= req_in.wr || req_in.rd;
            err_reg <= req_in.wr && (!(|hit) || !write_allowed || !(|(hit & wr_valid)));
            if (req_in.rd) begin
                rdata_out <= rdata_next;
            end
        end
    end
    assign ack_out = ack_reg;
    assign err_out = err_reg;

    // write during enabled power stage leaves value alone
    property p_locked(int i);
        @(posedge clock_in) disable iff (!reset_n_in)
        (req_in.wr && hit[i] && power_stage_enabled_in) |=> $stable(stored_reg[i]);
    endproperty
    chk_write_lock_p1: assert property (p_locked(0)) else $error("write taken while enabled");
    chk_write_lock_p2: assert property (p_locked(1)) else $error("write taken while enabled");
    chk_write_lock_p3: assert property (p_locked(2)) else $error("write taken while enabled");
    chk_write_lock_p4: assert property (p_locked(3)) else $error("write taken while enabled");
    // a locked write is answered with the error pulse
    chk_err_locked: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (req_in.wr && !write_allowed) |=> err_out)
        else $error("locked write not flagged");
    // codes offered per pin
    chk_bad_code: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (req_in.wr && hit[2] && req_in.wdata == lfm_pkg::FN_LIM_POS) |=> $stable(stored_reg[2]))
        else $error("pin three took limit code");
    chk_pos_limit_pin: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (req_in.wr && hit[0] && write_allowed && req_in.wdata == lfm_pkg::FN_LIM_POS)
        |=> stored_reg[0] == lfm_pkg::FN_LIM_POS) else $error("pin one refused limit");
    chk_neg_limit_pin: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (req_in.wr && hit[1] && write_allowed && req_in.wdata == lfm_pkg::FN_LIM_NEG)
        |=> stored_reg[1] == lfm_pkg::FN_LIM_NEG) else $error("pin two refused limit");
    // active copies load once after power-on, then hold
    chk_boot_load: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        boot_reg |=> active_reg[0] == $past(stored_reg[0])
        && active_reg[3] == $past(stored_reg[3]))
        else $error("active copy not loaded");
    chk_active_hold: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        !boot_reg |=> $stable(active_reg[0]) && $stable(active_reg[3]))
        else $error("active changed");
    // input routing
    chk_enable_local: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        !local_control_mode_in |-> !func_in_out.enable && !func_in_out.fault_reset)
        else $error("enable outside local mode");
    chk_free_halt: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (active_reg[1] == lfm_pkg::FN_HALT && pin_level_in[1]) |-> func_in_out.halt)
        else $error("halt not routed");
    // output functions drive their pins
    chk_output_drive: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (active_reg[2] == lfm_pkg::FN_NO_FAULT)
        |-> pin_oe_out[2] && pin_out[2] == func_out_in.no_fault)
        else $error("no fault output wrong");
    chk_free_out_drive: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (active_reg[3] == lfm_pkg::FN_FREE_OUT)
        |-> pin_oe_out[3] && pin_out[3] == free_out_level_in[3])
        else $error("free output wrong");
    // readback shows free inputs only
    chk_free_readback: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        act_free_in[2] |=> readback_reg[2] == $past(pin_level_in[2]))
        else $error("readback wrong");
    chk_readback_clear: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        !act_free_in[2] |=> !readback_reg[2])
        else $error("readback of non free pin");
    // power-on comes up in the factory roles
    chk_defaults: assert property (@(posedge clock_in) $rose(reset_n_in) |->
        active_reg[0] == lfm_pkg::RST_PIN1 && active_reg[3] == lfm_pkg::RST_PIN4)
        else $error("defaults wrong");
endmodule
`default_nettype wire

// [verification/lfm_switch_model.sv]
`timescale 1ns/1ps
`default_nettype none
// switches and external controls wired to the four local pins
module lfm_switch_model (
    input wire logic [3:0] pin_in,
    input wire logic [3:0] pin_oe_in,
    input wire logic [3:0] switch_in,
    output logic [3:0] level_out
);
    // a pin driven by the block shows its level, otherwise the contact level
    assign level_out = (pin_oe_in & pin_in) | (~pin_oe_in & switch_in);
endmodule
`default_nettype wire

// [verification/local_io_function_mux_test.sv]
`timescale 1ns/1ps
`default_nettype none
// bench for the local pin function selector
module local_io_function_mux_test;
    logic clock_in = 1'b0;
    logic reset_n_in = 1'b0;
    lfm_pkg::lfm_req_t req = '0;
    logic power_on = 1'b0;
    logic local_mode = 1'b0;
    logic [3:0] sw = 4'h0;
    logic [3:0] fol = 4'h0;
    lfm_pkg::lfm_func_out_t fo = '0;
    logic [3:0] lvl;
    logic [3:0] pin_o;
    logic [3:0] pin_oe;
    logic [15:0] rdata;
    logic ack;
    logic err;
    lfm_pkg::lfm_func_in_t fin;
    logic [15:0] rd_v;
    logic [15:0] cur [4] = '{16'h0015, 16'h0016, 16'h0001, 16'h0014};
    logic [15:0] codes [15] = '{16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0009,
        16'h000A, 16'h000B, 16'h0014, 16'h0015, 16'h0016, 16'h0065, 16'h0066,
        16'h0067, 16'h0005, 16'h0000};
    int mismatches = 0;
    int checks_done = 0;

    // clock at 4 ns period
    initial begin
        forever #2 clock_in = ~clock_in;
    end

    lfm_local_io_mux dut (
        .clock_in(clock_in), .reset_n_in(reset_n_in), .req_in(req),
        .rdata_out(rdata), .ack_out(ack), .err_out(err),
        .power_stage_enabled_in(power_on), .local_control_mode_in(local_mode),
        .pin_level_in(lvl), .pin_out(pin_o), .pin_oe_out(pin_oe),
        .free_out_level_in(fol), .func_out_in(fo), .func_in_out(fin)
    );

    lfm_switch_model sw_model (
        .pin_in(pin_o), .pin_oe_in(pin_oe), .switch_in(sw), .level_out(lvl)
    );

    // compare and count
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one register access, answer checked just after the taking edge
    task automatic access(input logic w, input logic [11:0] a, input logic [15:0] d,
                          input logic e);
        @(posedge clock_in);
        #1;
        req.wr = w;
        req.rd = ~w;
        req.addr = a;
        req.wdata = d;
        @(posedge clock_in);
        #1;
        req.wr = 1'b0;
        req.rd = 1'b0;
        check({15'h0, ack}, 16'h0001);
        check({15'h0, err}, {15'h0, e});
        rd_v = rdata;
    endtask

    // stored and active selections come up at factory values
    task automatic t_defaults();
        for (int i = 0; i < 4; i++) begin
            access(1'b0, lfm_pkg::OFS_PIN1_SEL + 12'(2 * i), 16'h0, 1'b0);
            check(rd_v, cur[i]);
            access(1'b0, lfm_pkg::OFS_ACTIVE_BASE + 12'(2 * i), 16'h0, 1'b0);
            check(rd_v, cur[i]);
        end
    endtask

    // every code on every pin, accepted or refused per pin
    task automatic t_codes();
        logic ok;
        for (int p = 0; p < 4; p++) begin
            for (int k = 0; k < 15; k++) begin
                ok = (k < 8) || (k > 9 && k < 13) || (k == 8 && p == 0) || (k == 9 && p == 1);
                access(1'b1, lfm_pkg::OFS_PIN1_SEL + 12'(2 * p), codes[k], ~ok);
                if (ok) begin
                    cur[p] = codes[k];
                end
                access(1'b0, lfm_pkg::OFS_PIN1_SEL + 12'(2 * p), 16'h0, 1'b0);
                check(rd_v, cur[p]);
            end
        end
    endtask

    // writes refused with the power stage on; pin three's active copy untouched
    task automatic t_power();
        power_on = 1'b1;
        access(1'b1, lfm_pkg::OFS_PIN1_SEL, 16'h0015, 1'b1);
        access(1'b1, lfm_pkg::OFS_PIN2_SEL, 16'h0016, 1'b1);
        access(1'b1, lfm_pkg::OFS_PIN3_SEL, 16'h0004, 1'b1);
        access(1'b1, lfm_pkg::OFS_PIN4_SEL, 16'h0014, 1'b1);
        power_on = 1'b0;
        for (int p = 0; p < 4; p++) begin
            access(1'b0, lfm_pkg::OFS_PIN1_SEL + 12'(2 * p), 16'h0, 1'b0);
            check(rd_v, cur[p]);
        end
        access(1'b0, lfm_pkg::OFS_ACTIVE_BASE + 12'h004, 16'h0, 1'b0);
        check(rd_v, 16'h0001);
    endtask

    // unmapped and read-only places
    task automatic t_unmapped();
        access(1'b0, 12'h7FE, 16'h0, 1'b0);
        check(rd_v, 16'h0000);
        access(1'b1, 12'h7FE, 16'h0001, 1'b1);
        access(1'b1, lfm_pkg::OFS_ACTIVE_BASE, 16'h0001, 1'b1);
        access(1'b0, lfm_pkg::OFS_ACTIVE_BASE, 16'h0, 1'b0);
        check(rd_v, 16'h0015);
    endtask

    // default input roles follow the switches; enable stays off
    task automatic t_pins();
        for (int v = 0; v < 16; v++) begin
            sw = 4'(v);
            local_mode = v[0];
            access(1'b0, lfm_pkg::OFS_READBACK, 16'h0, 1'b0);
            check(rd_v, {12'h000, 1'b0, sw[2], 2'b00});
            check({15'h0, fin.positive_limit_input}, {15'h0, sw[0]});
            check({15'h0, fin.negative_limit_input}, {15'h0, sw[1]});
            check({15'h0, fin.ref_switch}, {15'h0, sw[3]});
            check({14'h0, fin.fault_reset, fin.enable}, 16'h0000);
            check({12'h0, pin_oe}, 16'h0000);
        end
    endtask

    // new roles wait for a power-on, then drive and route the pins
    task automatic t_reboot();
        access(1'b1, lfm_pkg::OFS_PIN1_SEL, 16'h0003, 1'b0);
        access(1'b1, lfm_pkg::OFS_PIN2_SEL, 16'h0004, 1'b0);
        access(1'b1, lfm_pkg::OFS_PIN3_SEL, 16'h0066, 1'b0);
        access(1'b1, lfm_pkg::OFS_PIN4_SEL, 16'h0065, 1'b0);
        access(1'b0, lfm_pkg::OFS_ACTIVE_BASE, 16'h0, 1'b0);
        check(rd_v, 16'h0015);
        @(posedge clock_in);
        #1;
        reset_n_in = 1'b0;
        repeat (2) @(posedge clock_in);
        #1;
        reset_n_in = 1'b1;
        access(1'b0, lfm_pkg::OFS_PIN1_SEL, 16'h0, 1'b0);
        check(rd_v, 16'h0003);
        access(1'b0, lfm_pkg::OFS_ACTIVE_BASE, 16'h0, 1'b0);
        check(rd_v, 16'h0003);
        access(1'b0, lfm_pkg::OFS_ACTIVE_BASE + 12'h006, 16'h0, 1'b0);
        check(rd_v, 16'h0065);
        for (int v = 0; v < 8; v++) begin
            sw = {2'b00, v[1], v[0]};
            local_mode = v[2];
            fo.no_fault = v[1];
            fol = {v[0], 3'b000};
            access(1'b0, lfm_pkg::OFS_READBACK, 16'h0, 1'b0);
            check(rd_v, 16'h0000);
            check({15'h0, fin.enable}, {15'h0, v[0] & v[2]});
            check({15'h0, fin.halt}, {15'h0, v[1]});
            check({12'h0, pin_oe}, 16'h000C);
            check({12'h0, pin_o}, {12'h0, v[0], v[1], 2'b00});
        end
    endtask

    // report and stop
    task automatic end_sim();
        $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // cut a hang short
    initial begin
        #200000;
        mismatches++;
        end_sim();
    end

    // main sequence
    initial begin
        repeat (6) @(posedge clock_in);
        #1;
        reset_n_in = 1'b1;
        t_defaults();
        t_codes();
        t_power();
        t_unmapped();
        t_pins();
        t_reboot();
        end_sim();
    end
endmodule
`default_nettype wire
